// >>> pacd_top.sv
// Contract
// - Pump current code 010..111 gives 20,80,25,50,100,400 uA; 000/001 reserved.
// - Polarity bit 0 selects negative slope, 1 positive slope oscillator.
// - Crystal amplifier on when bit is 1; software sets it for a crystal.
// - Auxiliary output enable bit resets to 0, port starts disabled.
// - Global clock enable at bit 18 resets to 1; 1 enables outputs.
// - Sleep bit 1 powers down all blocks, overriding every other control; here the pump polarity output and the filter values still follow their bits.
// - Doubler bit resets 0; 1 routes reference through doubler, bypassing divider.
// - Resistor codes: 000 small, 001..100 10..40 kohm, 101..111 invalid.
// - Capacitor code 0000..1011 select twelve pairs; 1100..1111 reserved.
// - Each pump has its own high impedance bit; 1 floats, 0 active.
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pacd_top (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic CE,
	input wire logic [3:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic OUTPUTS_ENABLE_PIN,
	output logic [8:0] PUMP1_CURRENT_UA,
	output logic PUMP1_POS_SLOPE,
	output logic PUMP1_HIZ,
	output logic PUMP2_HIZ,
	output logic CRYSTAL_AMP_ON,
	output logic AUX_OUT_ON,
	output logic CLOCK_OUTPUTS_ON,
	output logic CHIP_SLEEP,
	output logic REF_DOUBLER_ON,
	output logic REF_DIVIDER_BYPASS,
	output logic [15:0] THIRD_POLE_OHMS,
	output logic [15:0] FOURTH_POLE_OHMS,
	output logic [7:0] THIRD_POLE_PF,
	output logic [7:0] FOURTH_POLE_PF,
	output logic CONFIG_INVALID
);
	// Decode of pump current code; validity comes from a separate PUMP_SEL_MIN compare
	function automatic logic [8:0] pump_ua(input logic [2:0] sel);
		case (sel)
			3'h2: pump_ua = 9'h014;
			3'h3: pump_ua = 9'h050;
			3'h4: pump_ua = 9'h019;
			3'h5: pump_ua = 9'h032;
			3'h6: pump_ua = 9'h064;
			3'h7: pump_ua = 9'h190;
			default: pump_ua = 9'h000;
		endcase
	endfunction

	// Configuration fields
	logic [2:0] first_loop_pump_current_sel_q;
	logic first_loop_pump_polarity_q;
	logic first_pump_hiz_bit_q;
	logic second_pump_hiz_bit_q;
	logic crystal_amp_enable_q;
	logic aux_out_enable_q;
	logic chip_sleep_bit_q;
	logic ref_doubler_enable_q;
	logic global_enable_q;
	logic [2:0] third_pole_res_sel_q;
	logic [2:0] fourth_pole_res_sel_q;
	logic [3:0] pole_cap_pair_sel_q;
	// Pin synchroniser; first stage read only by the second
	logic pin_meta_q;
	logic pin_sync_q;
	// Bus state
	pacd_pkg::pacd_state_t state_q;
	pacd_pkg::pacd_state_t state_d;

	// Bus decode
	wire req = AVS_READ | AVS_WRITE;
	wire take = CE & (state_q == pacd_pkg::PACD_IDLE) & req;
	wire wr_pump = take & AVS_WRITE & (AVS_ADDRESS == pacd_pkg::ADDR_PUMP_CFG);
	wire wr_osc = take & AVS_WRITE & (AVS_ADDRESS == pacd_pkg::ADDR_OSC_CFG);
	wire wr_filt = take & AVS_WRITE & (AVS_ADDRESS == pacd_pkg::ADDR_FILT_CFG);
	wire be0 = AVS_BYTEENABLE[0];
	wire be1 = AVS_BYTEENABLE[1];
	wire be2 = AVS_BYTEENABLE[2];

	// Field decoders
	wire [15:0] r3_ohms;
	wire [15:0] r4_ohms;
	wire r3_ok;
	wire r4_ok;
	wire [7:0] c3_pf;
	wire [7:0] c4_pf;
	wire cap_ok;
	pacd_res_decode #(.BASE_OHM(16'h0258)) u_r3 (
		.code(third_pole_res_sel_q),
		.ohms(r3_ohms),
		.valid(r3_ok)
	);
	pacd_res_decode #(.BASE_OHM(16'h00C8)) u_r4 (
		.code(fourth_pole_res_sel_q),
		.ohms(r4_ohms),
		.valid(r4_ok)
	);
	pacd_cap_decode u_cap (
		.code(pole_cap_pair_sel_q),
		.c3_pf(c3_pf),
		.c4_pf(c4_pf),
		.valid(cap_ok)
	);

	// Combined controls; sleep forces pump current, clocks, amplifier, aux and doubler off, pumps floating
	wire awake = ~chip_sleep_bit_q;
	wire pump_ok = (first_loop_pump_current_sel_q >= pacd_pkg::PUMP_SEL_MIN);
	wire [8:0] pump_cur = awake ? pump_ua(first_loop_pump_current_sel_q) : 9'h000;
	wire clk_on = awake & global_enable_q & pin_sync_q;
	// Pump floats in sleep too, so the loop filter is not driven
	wire hiz1 = first_pump_hiz_bit_q | chip_sleep_bit_q;
	wire hiz2 = second_pump_hiz_bit_q | chip_sleep_bit_q;
	wire dbl_on = awake & ref_doubler_enable_q;
	wire res_bad = ~(r3_ok & r4_ok);

	// Read mux; unmapped addresses return a marker word
	wire [31:0] rd_pump = {26'h0, second_pump_hiz_bit_q, first_pump_hiz_bit_q,
		first_loop_pump_polarity_q, first_loop_pump_current_sel_q};
	wire [31:0] rd_osc = {13'h0, global_enable_q, 14'h0, ref_doubler_enable_q,
		chip_sleep_bit_q, aux_out_enable_q, crystal_amp_enable_q};
	wire [31:0] rd_filt = {20'h0, pole_cap_pair_sel_q, 1'b0, fourth_pole_res_sel_q,
		1'b0, third_pole_res_sel_q};
	wire [31:0] rd_stat = {27'h0, pin_sync_q, clk_on, ~cap_ok, res_bad, ~pump_ok};
	wire [31:0] rd_mux = (AVS_ADDRESS == pacd_pkg::ADDR_PUMP_CFG) ? rd_pump :
		(AVS_ADDRESS == pacd_pkg::ADDR_OSC_CFG) ? rd_osc :
		(AVS_ADDRESS == pacd_pkg::ADDR_FILT_CFG) ? rd_filt :
		(AVS_ADDRESS == pacd_pkg::ADDR_STATUS) ? rd_stat : pacd_pkg::BAD_ADDR_DATA;

	// Response sequencing: take, then drop waitrequest one cycle
	always_comb begin
		case (state_q)
			pacd_pkg::PACD_IDLE: state_d = take ? pacd_pkg::PACD_ACK : pacd_pkg::PACD_IDLE;
			pacd_pkg::PACD_ACK: state_d = pacd_pkg::PACD_DONE;
			pacd_pkg::PACD_DONE: state_d = pacd_pkg::PACD_IDLE;
			default: state_d = pacd_pkg::PACD_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			state_q <= pacd_pkg::PACD_IDLE;
		end else if (CE) begin
			state_q <= state_d;
		end
	end

	// Waitrequest low only in ACK, with read data held there
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA <= 32'h0000_0000;
		end else if (CE) begin
			AVS_WAITREQUEST <= ~(state_d == pacd_pkg::PACD_ACK);
			AVS_READDATA <= take ? rd_mux : AVS_READDATA;
		end
	end

	// Pin passes two flops before use
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			pin_meta_q <= 1'b0;
			pin_sync_q <= 1'b0;
		end else if (CE) begin
			pin_meta_q <= OUTPUTS_ENABLE_PIN;
			pin_sync_q <= pin_meta_q;
		end
	end

	// Pump register; write applies at the take edge
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			first_loop_pump_current_sel_q <= pacd_pkg::PUMP_SEL_RST;
			first_loop_pump_polarity_q <= pacd_pkg::RST_ZERO;
			first_pump_hiz_bit_q <= pacd_pkg::RST_ZERO;
			second_pump_hiz_bit_q <= pacd_pkg::RST_ZERO;
		end else if (wr_pump & be0) begin
			first_loop_pump_current_sel_q <= AVS_WRITEDATA[pacd_pkg::PUMP_SEL_LSB +: 3];
			first_loop_pump_polarity_q <= AVS_WRITEDATA[pacd_pkg::PUMP_POL_BIT];
			first_pump_hiz_bit_q <= AVS_WRITEDATA[pacd_pkg::PUMP1_HIZ_BIT];
			second_pump_hiz_bit_q <= AVS_WRITEDATA[pacd_pkg::PUMP2_HIZ_BIT];
		end
	end

	// Oscillator and global register
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			crystal_amp_enable_q <= pacd_pkg::RST_ZERO;
			aux_out_enable_q <= pacd_pkg::RST_ZERO;
			chip_sleep_bit_q <= pacd_pkg::RST_ZERO;
			ref_doubler_enable_q <= pacd_pkg::RST_ZERO;
			global_enable_q <= pacd_pkg::GLOBAL_EN_RST;
		end else if (wr_osc) begin
			if (be0) begin
				crystal_amp_enable_q <= AVS_WRITEDATA[pacd_pkg::XTAL_EN_BIT];
				aux_out_enable_q <= AVS_WRITEDATA[pacd_pkg::AUX_OUT_BIT];
				chip_sleep_bit_q <= AVS_WRITEDATA[pacd_pkg::SLEEP_BIT];
				ref_doubler_enable_q <= AVS_WRITEDATA[pacd_pkg::DOUBLER_BIT];
			end
			if (be2) begin
				global_enable_q <= AVS_WRITEDATA[pacd_pkg::GLOBAL_EN_BIT];
			end
		end
	end

	// Filter register; invalid codes stored but flagged
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			third_pole_res_sel_q <= pacd_pkg::RES_RST;
			fourth_pole_res_sel_q <= pacd_pkg::RES_RST;
			pole_cap_pair_sel_q <= pacd_pkg::CAP_RST;
		end else if (wr_filt) begin
			if (be0) begin
				third_pole_res_sel_q <= AVS_WRITEDATA[pacd_pkg::RES3_LSB +: 3];
				fourth_pole_res_sel_q <= AVS_WRITEDATA[pacd_pkg::RES4_LSB +: 3];
			end
			if (be1) begin
				pole_cap_pair_sel_q <= AVS_WRITEDATA[pacd_pkg::CAP_LSB +: 4];
			end
		end
	end

	// Registered analog controls
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			PUMP1_CURRENT_UA <= 9'h000;
			PUMP1_POS_SLOPE <= 1'b0;
			PUMP1_HIZ <= 1'b0;
			PUMP2_HIZ <= 1'b0;
			CRYSTAL_AMP_ON <= 1'b0;
			AUX_OUT_ON <= 1'b0;
			CLOCK_OUTPUTS_ON <= 1'b0;
			CHIP_SLEEP <= 1'b0;
			REF_DOUBLER_ON <= 1'b0;
			REF_DIVIDER_BYPASS <= 1'b0;
		end else if (CE) begin
			PUMP1_CURRENT_UA <= pump_cur;
			PUMP1_POS_SLOPE <= first_loop_pump_polarity_q;
			PUMP1_HIZ <= hiz1;
			PUMP2_HIZ <= hiz2;
			CRYSTAL_AMP_ON <= awake & crystal_amp_enable_q;
			AUX_OUT_ON <= awake & aux_out_enable_q;
			CLOCK_OUTPUTS_ON <= clk_on;
			CHIP_SLEEP <= chip_sleep_bit_q;
			REF_DOUBLER_ON <= dbl_on;
			REF_DIVIDER_BYPASS <= dbl_on;
		end
	end

	// Registered filter values and combined validity flag
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			THIRD_POLE_OHMS <= 16'h0000;
			FOURTH_POLE_OHMS <= 16'h0000;
			THIRD_POLE_PF <= 8'h00;
			FOURTH_POLE_PF <= 8'h00;
			CONFIG_INVALID <= 1'b0;
		end else if (CE) begin
			THIRD_POLE_OHMS <= r3_ohms;
			FOURTH_POLE_OHMS <= r4_ohms;
			THIRD_POLE_PF <= c3_pf;
			FOURTH_POLE_PF <= c4_pf;
			CONFIG_INVALID <= ~pump_ok | res_bad | ~cap_ok;
		end
	end
endmodule
`default_nettype wire

// >>> pacd_pkg.sv
`default_nettype none
package pacd_pkg;
	// Register byte addresses (word aligned)
	localparam logic [3:0] ADDR_PUMP_CFG = 4'h0;
	localparam logic [3:0] ADDR_OSC_CFG = 4'h4;
	localparam logic [3:0] ADDR_FILT_CFG = 4'h8;
	localparam logic [3:0] ADDR_STATUS = 4'hC;
	// Pump config fields
	localparam int PUMP_SEL_LSB = 0;
	localparam int PUMP_POL_BIT = 3;
	localparam int PUMP1_HIZ_BIT = 4;
	localparam int PUMP2_HIZ_BIT = 5;
	// Oscillator / global config fields
	localparam int XTAL_EN_BIT = 0;
	localparam int AUX_OUT_BIT = 1;
	localparam int SLEEP_BIT = 2;
	localparam int DOUBLER_BIT = 3;
	localparam int GLOBAL_EN_BIT = 18;
	// Filter config fields
	localparam int RES3_LSB = 0;
	localparam int RES4_LSB = 4;
	localparam int CAP_LSB = 8;
	// Status fields
	localparam int ST_PUMP_BAD_BIT = 0;
	localparam int ST_RES_BAD_BIT = 1;
	localparam int ST_CAP_BAD_BIT = 2;
	localparam int ST_CLK_ON_BIT = 3;
	localparam int ST_PIN_BIT = 4;
	// Reset values
	localparam logic [2:0] PUMP_SEL_RST = 3'h2;
	localparam logic RST_ZERO = 1'b0;
	localparam logic GLOBAL_EN_RST = 1'b1;
	localparam logic [2:0] RES_RST = 3'h0;
	localparam logic [3:0] CAP_RST = 4'h0;
	// Decode limits
	localparam logic [2:0] PUMP_SEL_MIN = 3'h2;
	localparam logic [2:0] RES_MAX = 3'h4;
	localparam logic [3:0] CAP_MAX = 4'hB;
	localparam logic [31:0] BAD_ADDR_DATA = 32'hDEAD_BEEF;
	// Bus response state
	typedef enum logic [1:0] {
		PACD_IDLE = 2'b00,
		PACD_ACK = 2'b01,
		PACD_DONE = 2'b11
	} pacd_state_t;
endpackage
`default_nettype wire

// >>> pacd_res_decode.sv
`timescale 1ns/1ps
`default_nettype none
// Resistor code to ohms; base is the code 000 value
module pacd_res_decode #(
	parameter logic [15:0] BASE_OHM = 16'h0258
) (
	input wire logic [2:0] code,
	output logic [15:0] ohms,
	output logic valid
);
	// Codes 001..100 step by 10 kilohm; upper codes flagged
	assign valid = (code <= pacd_pkg::RES_MAX);
	assign ohms = (code == 3'h0) ? BASE_OHM :
		valid ? 16'(code * 16'h2710) : 16'h0000;
endmodule
`default_nettype wire

// >>> pacd_cap_decode.sv
`timescale 1ns/1ps
`default_nettype none
// Capacitor pair code to third/fourth pole picofarads
module pacd_cap_decode (
	input wire logic [3:0] code,
	output logic [7:0] c3_pf,
	output logic [7:0] c4_pf,
	output logic valid
);
	// Table lookup; reserved codes give zero and invalid
	assign valid = (code <= pacd_pkg::CAP_MAX);
	always_comb begin
		case (code)
			4'h0: {c3_pf, c4_pf} = {8'h00, 8'h0A};
			4'h1: {c3_pf, c4_pf} = {8'h00, 8'h3C};
			4'h2: {c3_pf, c4_pf} = {8'h32, 8'h0A};
			4'h3: {c3_pf, c4_pf} = {8'h00, 8'h6E};
			4'h4: {c3_pf, c4_pf} = {8'h32, 8'h6E};
			4'h5: {c3_pf, c4_pf} = {8'h64, 8'h6E};
			4'h6: {c3_pf, c4_pf} = {8'h00, 8'hA0};
			4'h7: {c3_pf, c4_pf} = {8'h32, 8'hA0};
			4'h8: {c3_pf, c4_pf} = {8'h64, 8'h0A};
			4'h9: {c3_pf, c4_pf} = {8'h64, 8'h3C};
			4'hA: {c3_pf, c4_pf} = {8'h96, 8'h6E};
			4'hB: {c3_pf, c4_pf} = {8'h96, 8'h3C};
			default: {c3_pf, c4_pf} = {8'h00, 8'h00};
		endcase
	end
endmodule
`default_nettype wire

// >>> pacd_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module pacd_top_props (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic AVS_WAITREQUEST,
	input wire logic OUTPUTS_ENABLE_PIN,
	input wire logic [8:0] PUMP1_CURRENT_UA,
	input wire logic PUMP1_HIZ,
	input wire logic PUMP2_HIZ,
	input wire logic CRYSTAL_AMP_ON,
	input wire logic AUX_OUT_ON,
	input wire logic CLOCK_OUTPUTS_ON,
	input wire logic CHIP_SLEEP,
	input wire logic REF_DOUBLER_ON,
	input wire logic REF_DIVIDER_BYPASS,
	input wire logic [15:0] THIRD_POLE_OHMS,
	input wire logic [15:0] FOURTH_POLE_OHMS,
	input wire logic [7:0] THIRD_POLE_PF
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);
	// A pending request must see one low waitrequest cycle soon
	sequence s_req;
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
	endsequence
	sequence s_ack;
		!AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
	endsequence
	a_bus_answer: assert property (s_req |-> ##[1:3] s_ack) else $error("bus answer late");
	a_pump_table: assert property (PUMP1_CURRENT_UA inside {9'h000, 9'h014, 9'h050, 9'h019,
		9'h032, 9'h064, 9'h190}) else $error("pump current off table");
	a_sleep_hiz: assert property (CHIP_SLEEP |-> PUMP1_HIZ && PUMP2_HIZ) else $error("pump drives in sleep");
	a_sleep_all: assert property (CHIP_SLEEP |-> !(CLOCK_OUTPUTS_ON || CRYSTAL_AMP_ON ||
		AUX_OUT_ON || REF_DOUBLER_ON)) else $error("block awake in sleep");
	a_doubler_pair: assert property (REF_DOUBLER_ON == REF_DIVIDER_BYPASS) else $error("doubler split");
	a_res3_table: assert property (THIRD_POLE_OHMS inside {16'h0000, 16'h0258, 16'h2710, 16'h4E20,
		16'h7530, 16'h9C40}) else $error("third resistor off table");
	a_res4_table: assert property (FOURTH_POLE_OHMS inside {16'h0000, 16'h00C8, 16'h2710, 16'h4E20,
		16'h7530, 16'h9C40}) else $error("fourth resistor off table");
	a_cap_table: assert property (THIRD_POLE_PF inside {8'h00, 8'h32, 8'h64, 8'h96})
		else $error("third cap off table");
	// Pin passes two sync flops and the output flop
	a_pin_gate: assert property (CLOCK_OUTPUTS_ON |-> $past(OUTPUTS_ENABLE_PIN, 3))
		else $error("clocks on without pin");
endmodule
bind pacd_top pacd_top_props u_props (.REF_CLK(REF_CLK), .RST(RST), .AVS_READ(AVS_READ),
	.AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .OUTPUTS_ENABLE_PIN(OUTPUTS_ENABLE_PIN),
	.PUMP1_CURRENT_UA(PUMP1_CURRENT_UA), .PUMP1_HIZ(PUMP1_HIZ), .PUMP2_HIZ(PUMP2_HIZ),
	.CRYSTAL_AMP_ON(CRYSTAL_AMP_ON), .AUX_OUT_ON(AUX_OUT_ON), .CLOCK_OUTPUTS_ON(CLOCK_OUTPUTS_ON),
	.CHIP_SLEEP(CHIP_SLEEP), .REF_DOUBLER_ON(REF_DOUBLER_ON), .REF_DIVIDER_BYPASS(REF_DIVIDER_BYPASS),
	.THIRD_POLE_OHMS(THIRD_POLE_OHMS), .FOURTH_POLE_OHMS(FOURTH_POLE_OHMS),
	.THIRD_POLE_PF(THIRD_POLE_PF));
`default_nettype wire

// >>> pacd_pump_model.sv
`timescale 1ns/1ps
`default_nettype none
// Analog side: a floating pump delivers no current, oscillator needs its amplifier
module pacd_pump_model (
	input wire logic hiz,
	input wire logic [8:0] ua,
	input wire logic amp_on,
	output logic [8:0] drive_ua,
	output logic osc_runs
);
	// Current reaches the loop filter only while the pump is active
	assign drive_ua = hiz ? 9'h000 : ua;
	assign osc_runs = amp_on;
endmodule
`default_nettype wire

// >>> pll_analog_config_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pll_analog_config_decode_tb;
	logic REF_CLK = 0, RST = 1, CE = 1, AVS_READ = 0, AVS_WRITE = 0, OUTPUTS_ENABLE_PIN = 1;
	logic [3:0] AVS_ADDRESS = 4'h0, AVS_BYTEENABLE = 4'hF;
	logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, q;
	logic AVS_WAITREQUEST, PUMP1_POS_SLOPE, PUMP1_HIZ, PUMP2_HIZ, CRYSTAL_AMP_ON, AUX_OUT_ON;
	logic CLOCK_OUTPUTS_ON, CHIP_SLEEP, REF_DOUBLER_ON, REF_DIVIDER_BYPASS, CONFIG_INVALID, osc_runs;
	logic [8:0] PUMP1_CURRENT_UA, drive_ua;
	logic [15:0] THIRD_POLE_OHMS, FOURTH_POLE_OHMS;
	logic [7:0] THIRD_POLE_PF, FOURTH_POLE_PF;
	int fails = 0, num_checks = 0;
	logic [8:0] ua_t [8] = '{9'h000, 9'h000, 9'h014, 9'h050, 9'h019, 9'h032, 9'h064, 9'h190};
	logic [15:0] r_t [8] = '{16'h0258, 16'h2710, 16'h4E20, 16'h7530, 16'h9C40, 0, 0, 0};
	logic [7:0] c3_t [16] = '{8'h00, 8'h00, 8'h32, 8'h00, 8'h32, 8'h64, 8'h00, 8'h32, 8'h64,
		8'h64, 8'h96, 8'h96, 0, 0, 0, 0};
	logic [7:0] c4_t [16] = '{8'h0A, 8'h3C, 8'h0A, 8'h6E, 8'h6E, 8'h6E, 8'hA0, 8'hA0, 8'h0A,
		8'h3C, 8'h6E, 8'h3C, 0, 0, 0, 0};
	logic [31:0] osc_t [3] = '{32'h0004_000B, 32'h0000_0003, 32'h0004_000F};
	pacd_top dut (.REF_CLK, .RST, .CE, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
		.AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .OUTPUTS_ENABLE_PIN, .PUMP1_CURRENT_UA,
		.PUMP1_POS_SLOPE, .PUMP1_HIZ, .PUMP2_HIZ, .CRYSTAL_AMP_ON, .AUX_OUT_ON, .CLOCK_OUTPUTS_ON,
		.CHIP_SLEEP, .REF_DOUBLER_ON, .REF_DIVIDER_BYPASS, .THIRD_POLE_OHMS, .FOURTH_POLE_OHMS,
		.THIRD_POLE_PF, .FOURTH_POLE_PF, .CONFIG_INVALID);
	pacd_pump_model model (.hiz(PUMP1_HIZ), .ua(PUMP1_CURRENT_UA), .amp_on(CRYSTAL_AMP_ON),
		.drive_ua(drive_ua), .osc_runs(osc_runs));
	// 25 MHz reference clock
	always #20 REF_CLK = ~REF_CLK;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// One bus cycle; the request stands until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		AVS_WRITE <= wr;
		AVS_READ <= !wr;
		@(posedge REF_CLK);
		// Only the watchdog may end this wait, so a hang is counted
		while (AVS_WAITREQUEST !== 1'b0) begin
			@(posedge REF_CLK);
		end
		q = AVS_READDATA;
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
		@(posedge REF_CLK);
	endtask
	task automatic end_of_test();
		$display("checks=%0d fails=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Watchdog: the sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge REF_CLK);
		fails++;
		end_of_test();
	end
	initial begin
		repeat (20) @(posedge REF_CLK);
		RST <= 1'b0;
		repeat (4) @(posedge REF_CLK);
		chk(PUMP1_CURRENT_UA, 9'h014);
		chk(AUX_OUT_ON, 1'b0);
		chk(CLOCK_OUTPUTS_ON, 1'b1);
		chk(REF_DOUBLER_ON, 1'b0);
		bus(1'b0, pacd_pkg::ADDR_OSC_CFG, 32'h0);
		chk(q[pacd_pkg::GLOBAL_EN_BIT], 1'b1);
		// Every pump code with polarity and float bits walked alongside
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, pacd_pkg::ADDR_PUMP_CFG, {26'h0, i[2], i[1], i[0], i[2:0]});
			chk(PUMP1_CURRENT_UA, ua_t[i]);
			chk(CONFIG_INVALID, i < 2);
			chk(PUMP1_POS_SLOPE, i[0]);
			chk({PUMP2_HIZ, PUMP1_HIZ}, i[2:1]);
			chk(drive_ua, i[1] ? 9'h000 : ua_t[i]);
		end
		// Every capacitor code, resistor codes riding on its low bits
		for (int i = 0; i < 16; i++) begin
			bus(1'b1, pacd_pkg::ADDR_FILT_CFG, {20'h0, i[3:0], 1'b0, i[2:0], 1'b0, i[2:0]});
			chk(THIRD_POLE_OHMS, r_t[i[2:0]]);
			chk(FOURTH_POLE_OHMS, i[2:0] == 0 ? 16'h00C8 : r_t[i[2:0]]);
			chk({THIRD_POLE_PF, FOURTH_POLE_PF}, {c3_t[i], c4_t[i]});
			chk(CONFIG_INVALID, i[2:0] > 4 || i > 11);
		end
		// Oscillator and global controls, last entry puts the chip to sleep
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, pacd_pkg::ADDR_OSC_CFG, osc_t[i]);
			chk(osc_runs, osc_t[i][0] & !osc_t[i][2]);
			chk(AUX_OUT_ON, osc_t[i][1] & !osc_t[i][2]);
			chk(CLOCK_OUTPUTS_ON, osc_t[i][18] & !osc_t[i][2]);
			chk({REF_DOUBLER_ON, REF_DIVIDER_BYPASS}, {2{osc_t[i][3] & !osc_t[i][2]}});
			chk(CHIP_SLEEP, osc_t[i][2]);
			chk(PUMP1_HIZ, 1'b1);
		end
		// Pin and bit must both permit the clocks
		bus(1'b1, pacd_pkg::ADDR_OSC_CFG, 32'h0004_0000);
		OUTPUTS_ENABLE_PIN <= 1'b0;
		repeat (4) @(posedge REF_CLK);
		chk(CLOCK_OUTPUTS_ON, 1'b0);
		// Clock enable low freezes the pin synchroniser and outputs
		CE <= 1'b0;
		OUTPUTS_ENABLE_PIN <= 1'b1;
		repeat (4) @(posedge REF_CLK);
		chk(CLOCK_OUTPUTS_ON, 1'b0);
		CE <= 1'b1;
		repeat (4) @(posedge REF_CLK);
		chk(CLOCK_OUTPUTS_ON, 1'b1);
		// Lane 0 only: the global enable in lane 2 must survive
		AVS_BYTEENABLE <= 4'h1;
		bus(1'b1, pacd_pkg::ADDR_OSC_CFG, 32'h0);
		AVS_BYTEENABLE <= 4'hF;
		chk(CLOCK_OUTPUTS_ON, 1'b1);
		bus(1'b0, pacd_pkg::ADDR_OSC_CFG, 32'h0);
		chk(q, 32'h0004_0000);
		// Doubler setup for a reference below 50 MHz, smallest pump current
		bus(1'b1, pacd_pkg::ADDR_PUMP_CFG, 32'h0000_0002);
		bus(1'b1, pacd_pkg::ADDR_FILT_CFG, 32'h0000_0210);
		bus(1'b1, pacd_pkg::ADDR_OSC_CFG, 32'h0004_0008);
		chk(PUMP1_CURRENT_UA, 9'h014);
		chk(drive_ua, 9'h014);
		chk({REF_DOUBLER_ON, REF_DIVIDER_BYPASS}, 2'h3);
		chk(THIRD_POLE_OHMS, 16'h0258);
		chk(FOURTH_POLE_OHMS, 16'h2710);
		chk({THIRD_POLE_PF, FOURTH_POLE_PF}, 16'h320A);
		chk(CONFIG_INVALID, 1'b0);
		// Readback: status, then the stored pump and filter fields
		bus(1'b0, pacd_pkg::ADDR_STATUS, 32'h0);
		chk(q, 32'h0000_0018);
		bus(1'b0, pacd_pkg::ADDR_PUMP_CFG, 32'h0);
		chk(q, 32'h0000_0002);
		bus(1'b0, pacd_pkg::ADDR_FILT_CFG, 32'h0);
		chk(q, 32'h0000_0210);
		bus(1'b0, 4'h2, 32'h0);
		chk(q, pacd_pkg::BAD_ADDR_DATA);
		end_of_test();
	end
endmodule
`default_nettype wire
